// ==== pkg/watchdog_pkg.sv ====
package watchdog_pkg;

    // Key codes
    localparam logic [7:0] KEY_START   = 8'hcc;
    localparam logic [7:0] KEY_REFRESH = 8'haa;
    localparam logic [7:0] KEY_UNLOCK  = 8'h55;

    // Register offsets
    localparam logic [7:0] ADDR_KEY     = 8'h00;
    localparam logic [7:0] ADDR_DIVIDER = 8'h01;
    localparam logic [7:0] ADDR_RELOAD  = 8'h02;

    // Reset values and field limits
    localparam logic [2:0] DIVIDER_RESET    = 3'h0;
    localparam logic [7:0] RELOAD_RESET     = 8'hff;
    localparam logic [7:0] START_COUNT      = 8'hff;
    localparam logic [7:0] COUNT_END        = 8'h00;
    localparam logic [2:0] DIVIDER_RESERVED = 3'h7;
    localparam logic [3:0] DIVIDER_SHIFT    = 4'h2;
    localparam logic [7:0] READ_IDLE        = 8'h00;

    // Oscillator periods between count end and reset request
    localparam logic [2:0] GRACE_EDGES = 3'h6;

    // Cycles after reset release in which the autostart strap is caught
    localparam logic [1:0] BOOT_CYCLES = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_RUN   = 4'h2,
        ST_GRACE = 4'h4,
        ST_FIRED = 4'h8
    } wd_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

endpackage

// ==== core/lsi_tick_gen.sv ====
`timescale 1ns/10ps
module osc_tick_gen (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic low_speed_internal_osc,
    output logic      osc_edge,
    output logic      count_tick
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic half;
        logic edge_pulse;
        logic tick_pulse;
    } tick_state_type;

    tick_state_type cur;
    tick_state_type next_cur;

    // Two-flop synchroniser, edge detect and halving of the oscillator
    always_comb begin
        logic rise;
        rise = 1'b0;
        next_cur = cur;
        next_cur.sync1 = low_speed_internal_osc;
        next_cur.sync2 = cur.sync1;
        next_cur.prev = cur.sync2;
        rise = cur.sync2 & ~cur.prev;
        next_cur.edge_pulse = rise;
        next_cur.tick_pulse = rise & cur.half;
        if (rise) begin
            next_cur.half = ~cur.half;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign osc_edge   = cur.edge_pulse;
    assign count_tick = cur.tick_pulse;

endmodule

// ==== core/independent_watchdog.sv ====
`timescale 1ns/10ps
module independent_watchdog (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire watchdog_pkg::reg_req_type reg_req,
    output logic [7:0]                     reg_rdata,
    input  wire logic                      low_speed_internal_osc,
    input  wire logic                      hardware_autostart_option,
    output logic                           system_reset_request,
    output logic                           watchdog_running
);

    typedef struct packed {
        watchdog_pkg::wd_state_type state;
        logic                       unlocked;
        logic [2:0]                 divider_code;
        logic [7:0]                 reload_value;
        logic [7:0]                 count;
        logic [7:0]                 prescale;
        logic [2:0]                 grace;
        logic [1:0]                 boot;
        logic                       opt_sync1;
        logic                       opt_sync2;
        logic [7:0]                 rdata;
        logic                       reset_req;
    } wd_core_type;

    wd_core_type cur;
    wd_core_type next_cur;

    logic osc_edge;
    logic count_tick;

    osc_tick_gen i_osc_tick_gen (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .low_speed_internal_osc (low_speed_internal_osc),
        .osc_edge               (osc_edge),
        .count_tick             (count_tick)
    );

    // Last prescale count for a divider code: 2^(code+2) - 1
    function automatic logic [7:0] prescale_last(input logic [2:0] code);
        logic [8:0] span;
        span = 9'h001 << ({1'b0, code} + watchdog_pkg::DIVIDER_SHIFT);
        return 8'(span - 9'h001);
    endfunction

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    always_comb begin
        logic key_wr;
        logic refresh;
        logic start;
        logic div_wr;
        logic rel_wr;
        key_wr = 1'b0;
        refresh = 1'b0;
        start = 1'b0;
        div_wr = 1'b0;
        rel_wr = 1'b0;
        next_cur = cur;

        // Strap synchroniser
        next_cur.opt_sync1 = hardware_autostart_option;
        next_cur.opt_sync2 = cur.opt_sync1;

        key_wr = reg_req.wr && addr_hit(reg_req.addr, watchdog_pkg::ADDR_KEY);
        div_wr = reg_req.wr && addr_hit(reg_req.addr, watchdog_pkg::ADDR_DIVIDER);
        rel_wr = reg_req.wr && addr_hit(reg_req.addr, watchdog_pkg::ADDR_RELOAD);

        // Catch the autostart strap once it has crossed the synchroniser
        if (cur.boot != watchdog_pkg::BOOT_CYCLES) begin
            next_cur.boot = cur.boot + 2'h1;
            if (cur.boot == watchdog_pkg::BOOT_CYCLES - 2'h1 && cur.opt_sync2) begin
                start = 1'b1;
            end
        end

        // Key decode; unlisted keys have no effect
        if (key_wr) begin
            if (reg_req.wdata == watchdog_pkg::KEY_START) begin
                start = 1'b1;
            end else if (reg_req.wdata == watchdog_pkg::KEY_UNLOCK) begin
                next_cur.unlocked = 1'b1;
            end else if (reg_req.wdata == watchdog_pkg::KEY_REFRESH) begin
                next_cur.unlocked = 1'b0;
                refresh = 1'b1;
            end
        end

        // Protected registers, writable in any state once unlocked
        if (div_wr && cur.unlocked) begin
            if (reg_req.wdata[2:0] != watchdog_pkg::DIVIDER_RESERVED) begin
                next_cur.divider_code = reg_req.wdata[2:0];
            end
        end
        if (rel_wr && cur.unlocked) begin
            next_cur.reload_value = reg_req.wdata;
        end

        // Counter sequencing
        unique case (cur.state)
            watchdog_pkg::ST_IDLE: begin
                if (start) begin
                    next_cur.state = watchdog_pkg::ST_RUN;
                    next_cur.count = watchdog_pkg::START_COUNT;
                    next_cur.prescale = '0;
                end
            end
            watchdog_pkg::ST_RUN: begin
                if (refresh) begin
                    next_cur.count = cur.reload_value;
                    next_cur.prescale = '0;
                end else if (count_tick) begin
                    if (cur.prescale == prescale_last(cur.divider_code)) begin
                        next_cur.prescale = '0;
                        if (cur.count == watchdog_pkg::COUNT_END) begin
                            next_cur.state = watchdog_pkg::ST_GRACE;
                            next_cur.grace = '0;
                        end else begin
                            next_cur.count = cur.count - 8'h01;
                        end
                    end else begin
                        next_cur.prescale = cur.prescale + 8'h01;
                    end
                end
            end
            watchdog_pkg::ST_GRACE: begin
                if (refresh) begin
                    next_cur.state = watchdog_pkg::ST_RUN;
                    next_cur.count = cur.reload_value;
                    next_cur.prescale = '0;
                end else if (osc_edge) begin
                    if (cur.grace == watchdog_pkg::GRACE_EDGES - 3'h1) begin
                        next_cur.state = watchdog_pkg::ST_FIRED;
                        next_cur.reset_req = 1'b1;
                    end else begin
                        next_cur.grace = cur.grace + 3'h1;
                    end
                end
            end
            watchdog_pkg::ST_FIRED: begin
                next_cur.reset_req = 1'b1;
            end
            default: begin
                next_cur.state = watchdog_pkg::ST_FIRED;
                next_cur.reset_req = 1'b1;
            end
        endcase

        // Read data stands in the cycle after the strobe only
        next_cur.rdata = watchdog_pkg::READ_IDLE;
        if (reg_req.rd) begin
            if (addr_hit(reg_req.addr, watchdog_pkg::ADDR_DIVIDER)) begin
                next_cur.rdata = {5'h00, cur.divider_code};
            end else if (addr_hit(reg_req.addr, watchdog_pkg::ADDR_RELOAD)) begin
                next_cur.rdata = cur.reload_value;
            end else begin
                next_cur.rdata = watchdog_pkg::READ_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur <= '0;
            cur.state <= watchdog_pkg::ST_IDLE;
            cur.divider_code <= watchdog_pkg::DIVIDER_RESET;
            cur.reload_value <= watchdog_pkg::RELOAD_RESET;
            cur.count <= watchdog_pkg::START_COUNT;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata            = cur.rdata;
    assign system_reset_request = cur.reset_req;
    assign watchdog_running     = cur.state != watchdog_pkg::ST_IDLE;

endmodule

// ==== testbench/independent_watchdog_props.sv ====
`timescale 1ns/10ps
module independent_watchdog_props (
    input wire logic                      ref_clk,
    input wire logic                      rst,
    input wire watchdog_pkg::reg_req_type reg_req,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      low_speed_internal_osc,
    input wire logic                      hardware_autostart_option,
    input wire logic                      system_reset_request,
    input wire logic                      watchdog_running
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic key_wr;
    assign key_wr = reg_req.wr && reg_req.addr == watchdog_pkg::ADDR_KEY;

    a_start_runs: assert property (key_wr && reg_req.wdata == watchdog_pkg::KEY_START
        |=> watchdog_running) else $error("start key ignored");
    a_fire_sticky: assert property (system_reset_request
        |=> system_reset_request) else $error("reset request dropped");
    a_fire_running: assert property ($rose(system_reset_request)
        |-> watchdog_running) else $error("fired while idle");
    a_idle_quiet: assert property (!watchdog_running
        |-> !system_reset_request) else $error("request without run");
    a_refresh_defers: assert property (key_wr
        && reg_req.wdata == watchdog_pkg::KEY_REFRESH
        && watchdog_running && !system_reset_request
        |=> !system_reset_request [*8]) else $error("fired soon after refresh");
    a_run_sticky: assert property (watchdog_running
        |=> watchdog_running) else $error("watchdog stopped");
    a_key_unread: assert property (reg_req.rd && reg_req.addr == watchdog_pkg::ADDR_KEY
        |=> reg_rdata == watchdog_pkg::READ_IDLE) else $error("key read not zero");
    a_unmapped_zero: assert property (reg_req.rd
        && reg_req.addr > watchdog_pkg::ADDR_RELOAD
        |=> reg_rdata == watchdog_pkg::READ_IDLE) else $error("unmapped read not zero");
    a_divider_width: assert property (reg_req.rd
        && reg_req.addr == watchdog_pkg::ADDR_DIVIDER
        |=> reg_rdata[7:3] == 5'h00) else $error("divider upper bits set");

    c_start: cover property ($rose(watchdog_running));
    c_fire: cover property ($rose(system_reset_request));
    c_unlock: cover property (key_wr && reg_req.wdata == watchdog_pkg::KEY_UNLOCK);
endmodule

bind independent_watchdog independent_watchdog_props i_props (
    .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .low_speed_internal_osc(low_speed_internal_osc),
    .hardware_autostart_option(hardware_autostart_option),
    .system_reset_request(system_reset_request), .watchdog_running(watchdog_running));

// ==== testbench/key_unlocked_watchdog_tb.sv ====
`timescale 1ns/10ps
module key_unlocked_watchdog_tb;
    logic                      ref_clk;
    logic                      rst;
    watchdog_pkg::reg_req_type req;
    logic [7:0]                reg_rdata;
    logic                      osc;
    logic                      strap;
    logic                      srr;
    logic                      running;
    int                        fail_count;
    int                        n_checks;
    int                        seed;
    int                        e;
    logic [7:0]                r;

    independent_watchdog i_independent_watchdog (
        .ref_clk(ref_clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
        .low_speed_internal_osc(osc), .hardware_autostart_option(strap),
        .system_reset_request(srr), .watchdog_running(running));

    always #25 ref_clk = ~ref_clk;
    always #200 osc = ~osc;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Oscillator periods from refresh to reset request
    function automatic int exp_delay(input int code, input int reload);
        return 2 * (4 << code) * (reload + 1) + 6;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge ref_clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, x);
    endtask

    // Ref cycles until the request, eight per oscillator period; halved clock phase is free
    task automatic fire(input int n);
        int c;
        c = 0;
        while (srr !== 1'b1 && c < (n + 3) * 8) begin
            @(negedge ref_clk);
            c++;
        end
        check(8'(c >= (n - 2) * 8 && c <= (n + 1) * 8), 8'h01);
    endtask

    task automatic do_rst(input logic s);
        @(posedge ref_clk);
        rst <= 1'b1;
        strap <= s;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
    endtask

    task automatic summarize();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        seed = 28848;
        ref_clk = 1'b0;
        osc = 1'b0;
        rst = 1'b1;
        strap = 1'b0;
        req = '0;
        fail_count = 0;
        n_checks = 0;
        do_rst(1'b0);
        rd(watchdog_pkg::ADDR_DIVIDER, 8'h00);
        rd(watchdog_pkg::ADDR_RELOAD, 8'hff);
        rd(watchdog_pkg::ADDR_KEY, 8'h00);
        rd(8'h03 | 8'($random(seed)), 8'h00);
        wr(watchdog_pkg::ADDR_RELOAD, 8'h12);
        rd(watchdog_pkg::ADDR_RELOAD, 8'hff);
        wr(watchdog_pkg::ADDR_KEY, {4'h1, 4'($random(seed))});
        check({7'h0, running}, 8'h00);
        wr(watchdog_pkg::ADDR_KEY, watchdog_pkg::KEY_UNLOCK);
        wr(watchdog_pkg::ADDR_DIVIDER, 8'h07);
        rd(watchdog_pkg::ADDR_DIVIDER, 8'h00);
        wr(watchdog_pkg::ADDR_KEY, watchdog_pkg::KEY_REFRESH);
        wr(watchdog_pkg::ADDR_RELOAD, 8'h12);
        rd(watchdog_pkg::ADDR_RELOAD, 8'hff);
        for (int c = 0; c < 7; c++) begin
            do_rst(1'b0);
            r = 8'($random(seed)) & 8'h01;
            wr(watchdog_pkg::ADDR_KEY, watchdog_pkg::KEY_START);
            check({7'h0, running}, 8'h01);
            wr(watchdog_pkg::ADDR_KEY, watchdog_pkg::KEY_UNLOCK);
            wr(watchdog_pkg::ADDR_DIVIDER, 8'(c));
            wr(watchdog_pkg::ADDR_RELOAD, r);
            rd(watchdog_pkg::ADDR_DIVIDER, 8'(c));
            rd(watchdog_pkg::ADDR_RELOAD, r);
            e = exp_delay(c, r);
            wr(watchdog_pkg::ADDR_KEY, watchdog_pkg::KEY_REFRESH);
            repeat (e * 4) @(negedge ref_clk);
            check({7'h0, srr}, 8'h00);
            wr(watchdog_pkg::ADDR_KEY, watchdog_pkg::KEY_REFRESH);
            fire(e);
            check({7'h0, running}, 8'h01);
        end
        do_rst(1'b1);
        fire(exp_delay(0, 255));
        summarize();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end
endmodule
